// file: elc_pkg.sv
// Package: constants, types and register layout of the low-power control
package elc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] ELC_IDX_BRK_EXIT = 16'hFE00;
  localparam logic [15:0] ELC_IDX_RST_CAUSE = 16'hFE01;
  localparam logic [15:0] ELC_IDX_BRK_FCLR = 16'hFE03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ELC_BRK_EXIT_BIT = 1;
  localparam int ELC_RC_POR_BIT = 7;
  localparam int ELC_RC_PIN_BIT = 6;
  localparam int ELC_RC_WDOG_BIT = 5;
  localparam int ELC_RC_ILLOP_BIT = 4;
  localparam int ELC_RC_ILLAD_BIT = 3;
  localparam int ELC_RC_LVI_BIT = 1;
  localparam int ELC_BFC_ENABLE_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic ELC_BRK_EXIT_RST = 1'b0;
  localparam logic ELC_BFC_ENABLE_RST = 1'b0;
  localparam logic ELC_RC_POR_RST = 1'b1;
  localparam logic [4:0] ELC_RC_SRC_RST = 5'h00;

  // ----------------------------------------------------------------
  // Stop recovery, in crystal clock cycles
  // ----------------------------------------------------------------
  localparam int ELC_REC_CNT_W = 13;
  localparam logic [12:0] ELC_REC_LONG_CYC = 13'h1000;
  localparam logic [12:0] ELC_REC_SHORT_CYC = 13'h0020;

  // ----------------------------------------------------------------
  // Bus answers and decode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ELC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ELC_RESP_DECERR = 2'h3;
  localparam logic [1:0] ELC_SEL_BRK_EXIT = 2'h0;
  localparam logic [1:0] ELC_SEL_RST_CAUSE = 2'h1;
  localparam logic [1:0] ELC_SEL_BRK_FCLR = 2'h2;
  localparam logic [1:0] ELC_SEL_NONE = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ELC_ST_RUN = 4'b0001,
    ELC_ST_WAIT = 4'b0010,
    ELC_ST_STOP = 4'b0100,
    ELC_ST_RECOVER = 4'b1000
  } elc_state_t;

  typedef struct packed {
    logic pin;
    logic wdog;
    logic illop;
    logic illad;
    logic low_voltage_reset_flag;
  } elc_rst_src_t;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic base;
    logic xtal;
  } elc_clk_en_t;

endpackage

// file: elc_recovery_counter.sv
// Stop recovery counter, held cleared until recovery begins
`timescale 1ns/1ps
module elc_recovery_counter #(
  parameter int CNT_W = elc_pkg::ELC_REC_CNT_W
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Control
  input wire logic hold_i,
  input wire logic tick_i,
  input wire logic [CNT_W-1:0] target_i,
  // Status
  output logic done_o
);
  import elc_pkg::*;

  logic [CNT_W-1:0] count;

  // ----------------------------------------------------------------
  // Count crystal ticks; done rises on the last one
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (hold_i) begin
        count <= '0;
        done_o <= 1'b0;
      end else if (tick_i && !done_o) begin
        count <= count + 1'b1;
        done_o <= (count == target_i - 1'b1);
      end
    end
  end

endmodule

// file: exception_lowpower_control.sv
// Exception, break and low-power control with its status registers
`timescale 1ns/1ps
module exception_lowpower_control #(
  parameter int ADDR_W = 20
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Reset sources
  input wire elc_pkg::elc_rst_src_t rst_src_i,
  output logic sys_reset_o,
  // CPU core
  input wire logic stop_exec_i,
  input wire logic wait_exec_i,
  input wire logic irq_req_i,
  output logic clr_imask_o,
  output logic stack_start_o,
  output logic force_swi_o,
  // Break module
  input wire logic break_req_i,
  input wire logic break_done_i,
  output logic break_mode_o,
  output logic flag_clear_allow_o,
  // Mask options
  input wire logic watchdog_disable_i,
  input wire logic short_stop_recovery_i,
  output logic wdog_enable_o,
  output logic wdog_run_o,
  // Clock generator
  input wire logic crystal_clock_tick_i,
  output elc_pkg::elc_clk_en_t clk_en_o
);
  import elc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  elc_state_t state;
  elc_state_t next_state;
  logic [4:0] src_vec;
  logic any_rst;
  logic break_mode;
  logic brk_pend;
  logic wake_by_brk;
  logic brk_hit;
  logic rec_done;
  logic rec_hold;
  logic [ELC_REC_CNT_W-1:0] rec_target;
  logic brk_exit_flag;
  logic bfc_enable;
  logic rc_por;
  logic [4:0] rc_src;
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [1:0] wr_sel;
  logic ar_take;
  logic [1:0] rd_sel;
  logic rc_read_clr;
  logic brk_exit_set;
  logic brk_exit_clr;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] elc_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] w;
    w = a[ADDR_W-1:2];
    if (w == (ADDR_W-2)'(ELC_IDX_BRK_EXIT))
      elc_decode = ELC_SEL_BRK_EXIT;
    else if (w == (ADDR_W-2)'(ELC_IDX_RST_CAUSE))
      elc_decode = ELC_SEL_RST_CAUSE;
    else if (w == (ADDR_W-2)'(ELC_IDX_BRK_FCLR))
      elc_decode = ELC_SEL_BRK_FCLR;
    else
      elc_decode = ELC_SEL_NONE;
  endfunction

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  assign src_vec = rst_src_i;
  assign any_rst = |src_vec;
  assign sys_reset_o = any_rst;

  // ----------------------------------------------------------------
  // Low-power state machine
  // ----------------------------------------------------------------
  assign brk_hit = break_req_i && !break_mode && !brk_pend;

  always_comb begin
    next_state = state;
    case (state)
      ELC_ST_RUN: begin
        if (stop_exec_i)
          next_state = ELC_ST_STOP;
        else if (wait_exec_i)
          next_state = ELC_ST_WAIT;
      end
      ELC_ST_WAIT: begin
        if (brk_hit || irq_req_i)
          next_state = ELC_ST_RUN;
      end
      ELC_ST_STOP: begin
        if (brk_hit || irq_req_i)
          next_state = ELC_ST_RECOVER;
      end
      ELC_ST_RECOVER: begin
        if (rec_done)
          next_state = ELC_ST_RUN;
      end
      default: begin
        next_state = ELC_ST_RUN;
      end
    endcase
    if (any_rst)
      next_state = ELC_ST_RUN;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i)
      state <= ELC_ST_RUN;
    else if (ce_i)
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Clock gating, registered from the next state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      clk_en_o <= '{cpu: 1'b1, periph: 1'b1, base: 1'b1, xtal: 1'b1};
    end else if (ce_i) begin
      clk_en_o.cpu <= (next_state == ELC_ST_RUN);
      clk_en_o.periph <= (next_state == ELC_ST_RUN) ||
                         (next_state == ELC_ST_WAIT);
      // Oscillator restarts during recovery, CPU stays unclocked
      clk_en_o.base <= (next_state != ELC_ST_STOP);
      clk_en_o.xtal <= (next_state != ELC_ST_STOP);
    end
  end

  // ----------------------------------------------------------------
  // CPU pulses: mask clear, stacking start, forced vector
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      clr_imask_o <= 1'b0;
      stack_start_o <= 1'b0;
      force_swi_o <= 1'b0;
    end else if (ce_i) begin
      clr_imask_o <= 1'b0;
      stack_start_o <= 1'b0;
      force_swi_o <= 1'b0;
      if (!any_rst) begin
        case (state)
          ELC_ST_RUN: begin
            clr_imask_o <= stop_exec_i || wait_exec_i;
            force_swi_o <= brk_hit && !stop_exec_i &&
                           !wait_exec_i;
          end
          ELC_ST_WAIT: begin
            force_swi_o <= brk_hit;
            stack_start_o <= irq_req_i && !brk_hit;
          end
          ELC_ST_RECOVER: begin
            // Nothing is stacked until the counter has run out
            force_swi_o <= rec_done && wake_by_brk;
            stack_start_o <= rec_done && !wake_by_brk;
          end
          default: begin
            stack_start_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Break tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      break_mode <= 1'b0;
      brk_pend <= 1'b0;
      wake_by_brk <= 1'b0;
    end else if (ce_i) begin
      if (any_rst) begin
        break_mode <= 1'b0;
        brk_pend <= 1'b0;
        wake_by_brk <= 1'b0;
      end else begin
        if (state == ELC_ST_STOP && (brk_hit || irq_req_i)) begin
          wake_by_brk <= brk_hit;
          brk_pend <= brk_hit;
        end
        if ((state == ELC_ST_RUN && brk_hit && !stop_exec_i &&
             !wait_exec_i) || (state == ELC_ST_WAIT && brk_hit) ||
            (state == ELC_ST_RECOVER && rec_done && wake_by_brk)) begin
          break_mode <= 1'b1;
          brk_pend <= 1'b0;
        end else if (break_done_i) begin
          break_mode <= 1'b0;
        end
      end
    end
  end

  assign break_mode_o = break_mode;
  // One enable for both steps of a two-step clear, so a first step
  // taken before break cannot complete inside it
  assign flag_clear_allow_o = !break_mode || bfc_enable;

  // ----------------------------------------------------------------
  // Watchdog option
  // ----------------------------------------------------------------
  assign wdog_enable_o = !watchdog_disable_i;
  assign wdog_run_o = !watchdog_disable_i &&
                      (state == ELC_ST_RUN ||
                       state == ELC_ST_WAIT);

  // ----------------------------------------------------------------
  // Stop recovery timer
  // ----------------------------------------------------------------
  assign rec_hold = (state != ELC_ST_RECOVER) || any_rst;
  assign rec_target = short_stop_recovery_i ? ELC_REC_SHORT_CYC :
                      ELC_REC_LONG_CYC;

  elc_recovery_counter #(
    .CNT_W(ELC_REC_CNT_W)
  ) u_rec_cnt (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .hold_i(rec_hold),
    .tick_i(crystal_clock_tick_i),
    .target_i(rec_target),
    .done_o(rec_done)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !aw_full && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_full && !s_axi_bvalid_o;
  assign do_write = aw_full && w_full && !s_axi_bvalid_o;
  assign wr_sel = elc_decode(aw_addr);

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= ELC_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_sel == ELC_SEL_NONE) ? ELC_RESP_DECERR :
                         ELC_RESP_OKAY;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Break-exit flag and clear enable
  // ----------------------------------------------------------------
  assign brk_exit_set = brk_hit && !any_rst &&
                        (state == ELC_ST_WAIT ||
                         state == ELC_ST_STOP);
  assign brk_exit_clr = do_write && wr_sel == ELC_SEL_BRK_EXIT &&
                        w_strb[0] &&
                        !w_data[ELC_BRK_EXIT_BIT];

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      brk_exit_flag <= ELC_BRK_EXIT_RST;
    end else if (ce_i) begin
      if (any_rst)
        brk_exit_flag <= 1'b0;
      else if (brk_exit_set)
        brk_exit_flag <= 1'b1;
      else if (brk_exit_clr)
        brk_exit_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      bfc_enable <= ELC_BFC_ENABLE_RST;
    end else if (ce_i) begin
      if (do_write && wr_sel == ELC_SEL_BRK_FCLR && w_strb[0])
        bfc_enable <= w_data[ELC_BFC_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Reset-cause flags
  // ----------------------------------------------------------------
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_sel = elc_decode(s_axi_araddr_i);
  assign rc_read_clr = ar_take && rd_sel == ELC_SEL_RST_CAUSE;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rc_por <= ELC_RC_POR_RST;
    end else if (ce_i) begin
      if (any_rst || rc_read_clr)
        rc_por <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_rc_flag
      always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
          rc_src[gi] <= ELC_RC_SRC_RST[gi];
        end else if (ce_i) begin
          // New source wins over a read in the same cycle
          if (any_rst)
            rc_src[gi] <= src_vec[gi];
          else if (rc_read_clr)
            rc_src[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      ELC_SEL_BRK_EXIT: begin
        rd_byte[ELC_BRK_EXIT_BIT] = brk_exit_flag;
      end
      ELC_SEL_RST_CAUSE: begin
        rd_byte[ELC_RC_POR_BIT] = rc_por;
        rd_byte[ELC_RC_PIN_BIT] = rc_src[4];
        rd_byte[ELC_RC_WDOG_BIT] = rc_src[3];
        rd_byte[ELC_RC_ILLOP_BIT] = rc_src[2];
        rd_byte[ELC_RC_ILLAD_BIT] = rc_src[1];
        rd_byte[ELC_RC_LVI_BIT] = rc_src[0];
      end
      ELC_SEL_BRK_FCLR: begin
        rd_byte[ELC_BFC_ENABLE_BIT] = bfc_enable;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= ELC_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h00_0000, rd_byte};
        s_axi_rresp_o <= (rd_sel == ELC_SEL_NONE) ? ELC_RESP_DECERR :
                         ELC_RESP_OKAY;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule

// file: elc_monitor.sv
// Port checks for the exception and low-power control
`timescale 1ns/1ps
module elc_monitor (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Reset sources
  input wire elc_pkg::elc_rst_src_t rst_src_i,
  input wire logic sys_reset_o,
  // CPU and break
  input wire logic stop_exec_i,
  input wire logic wait_exec_i,
  input wire logic irq_req_i,
  input wire logic clr_imask_o,
  input wire logic stack_start_o,
  input wire logic force_swi_o,
  input wire logic break_req_i,
  input wire logic break_mode_o,
  input wire logic flag_clear_allow_o,
  // Options and clocks
  input wire logic watchdog_disable_i,
  input wire logic short_stop_recovery_i,
  input wire logic wdog_enable_o,
  input wire logic wdog_run_o,
  input wire logic crystal_clock_tick_i,
  input wire elc_pkg::elc_clk_en_t clk_en_o
);
  import elc_pkg::*;
  logic calm;
  logic [12:0] need, ticks;
  assign calm = ce_i && !sys_reset_o;
  assign need = short_stop_recovery_i ? ELC_REC_SHORT_CYC : ELC_REC_LONG_CYC;
  // Cleared in stop, so each recovery is timed from zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || clk_en_o == 4'h0)
      ticks <= 13'h0000;
    else if (ce_i && clk_en_o == 4'h3 && crystal_clock_tick_i)
      ticks <= ticks + 13'h0001;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_reset_top:
  assert property (sys_reset_o == (|rst_src_i)) else $error("reset or wrong");
  a_break_entry:
  assert property (calm && break_req_i && clk_en_o.periph && !break_mode_o
    && !force_swi_o && !stop_exec_i && !wait_exec_i
    |=> force_swi_o ##[0:1] break_mode_o) else $error("no break entry");
  a_flag_guard:
  assert property (!break_mode_o |-> flag_clear_allow_o)
    else $error("guarded outside break");
  a_imask_clear:
  assert property (calm && clk_en_o == 4'hf && (stop_exec_i || wait_exec_i)
    |=> clr_imask_o) else $error("mask not cleared");
  a_wait_clocks:
  assert property (calm && clk_en_o == 4'hf && wait_exec_i && !stop_exec_i
    |=> clk_en_o == 4'h7) else $error("wait clocks wrong");
  a_wait_wake:
  assert property (calm && clk_en_o == 4'h7 && irq_req_i && !break_req_i
    |-> ##[1:2] stack_start_o) else $error("no wake from wait");
  a_wdog_option:
  assert property (wdog_enable_o == !watchdog_disable_i
    && (clk_en_o != 4'h7 || wdog_run_o == wdog_enable_o))
    else $error("watchdog state wrong");
  a_stop_clocks:
  assert property (calm && clk_en_o == 4'hf && stop_exec_i
    |=> clk_en_o == 4'h0) else $error("stop clocks wrong");
  a_stop_hold:
  assert property (calm && clk_en_o == 4'h0 && !irq_req_i && !break_req_i
    |=> clk_en_o == 4'h0) else $error("stop left early");
  a_recov_time:
  assert property (calm && $past(clk_en_o) == 4'h3 && clk_en_o != 4'h3
    && !$past(sys_reset_o) |-> ticks >= need && ticks <= need + 13'h0002)
    else $error("recovery length wrong");
  c_wake: cover property (clk_en_o == 4'h7 ##[1:2] stack_start_o);
  c_break: cover property (force_swi_o);
  c_recover: cover property (clk_en_o == 4'h3 ##1 clk_en_o == 4'hf);
endmodule

// file: elc_far_model.sv
// Far side: break module handshake and gated crystal ticks
`timescale 1ns/1ps
module elc_far_model #(
  parameter int DIV = 2
) (
  // Bench control
  input wire logic core_clk_i,
  input wire logic go_i,
  input wire logic end_i,
  // From the device
  input wire logic break_mode_i,
  input wire logic xtal_en_i,
  // To the device
  output logic break_req_o,
  output logic break_done_o,
  output logic tick_o
);
  int div_cnt = 0;
  logic req = 1'b0;
  logic done = 1'b0;
  // Request held until the device shows break
  always @(posedge core_clk_i) begin
    if (go_i)
      req <= 1'b1;
    else if (break_mode_i)
      req <= 1'b0;
    done <= end_i && break_mode_i;
  end
  // No ticks while the crystal output is gated off
  always @(posedge core_clk_i) begin
    if (!xtal_en_i || div_cnt == DIV - 1)
      div_cnt <= 0;
    else
      div_cnt <= div_cnt + 1;
  end
  assign break_req_o = req;
  assign break_done_o = done;
  assign tick_o = xtal_en_i && div_cnt == DIV - 1;
endmodule

// file: exception_lowpower_control_bench.sv
// Self-checking bench for the exception and low-power control
`timescale 1ns/1ps
module exception_lowpower_control_bench;
  import elc_pkg::*;
  localparam int DIV = 2;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [19:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'h1;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  elc_rst_src_t rst_src_i = '0;
  logic stop_exec_i = 1'b0, wait_exec_i = 1'b0, irq_req_i = 1'b0;
  logic watchdog_disable_i = 1'b0, short_stop_recovery_i = 1'b0;
  logic sys_reset_o, clr_imask_o, stack_start_o, force_swi_o, break_mode_o;
  logic flag_clear_allow_o, wdog_enable_o, wdog_run_o;
  logic break_req_i, break_done_i, crystal_clock_tick_i;
  logic brk_go = 1'b0, brk_end = 1'b0;
  elc_clk_en_t clk_en_o;
  logic [33:0] expq[$];
  logic [31:0] seed = 32'h0000_cbfa;
  int fail_count = 0;
  int checks_done = 0;
  exception_lowpower_control #(.ADDR_W(20)) dut (
    .core_clk_i, .rst_b_i, .ce_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .rst_src_i,
    .sys_reset_o, .stop_exec_i, .wait_exec_i, .irq_req_i, .clr_imask_o,
    .stack_start_o, .force_swi_o, .break_req_i, .break_done_i,
    .break_mode_o, .flag_clear_allow_o, .watchdog_disable_i,
    .short_stop_recovery_i, .wdog_enable_o, .wdog_run_o,
    .crystal_clock_tick_i, .clk_en_o);
  elc_far_model #(.DIV(DIV)) far (.core_clk_i, .go_i(brk_go),
    .end_i(brk_end), .break_mode_i(break_mode_o), .xtal_en_i(clk_en_o.xtal),
    .break_req_o(break_req_i), .break_done_o(break_done_i),
    .tick_o(crystal_clock_tick_i));
  always #4 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  always @(posedge core_clk_i) seed <= xs(seed);
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ------------------------------
  // Bus tasks and scoreboard
  // ------------------------------
  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
    input logic [1:0] r);
    logic a = 1'b0, w = 1'b0;
    expq.push_back({r, 32'h0000_0000});
    @(posedge core_clk_i);
    s_axi_awaddr_i <= {2'b00, idx, 2'b00};
    s_axi_wdata_i <= {seed[31:8], d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!(a && w)) begin
      @(negedge core_clk_i);
      a = a | (s_axi_awvalid_i & s_axi_awready_o);
      w = w | (s_axi_wvalid_i & s_axi_wready_o);
      @(posedge core_clk_i);
      if (a) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
    end
    do @(negedge core_clk_i); while (!s_axi_bvalid_o);
    @(posedge core_clk_i);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [33:0] e);
    expq.push_back(e);
    @(posedge core_clk_i);
    s_axi_araddr_i <= {2'b00, idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(negedge core_clk_i); while (!s_axi_arready_o);
    @(posedge core_clk_i);
    s_axi_arvalid_i <= 1'b0;
    do @(negedge core_clk_i); while (!s_axi_rvalid_o);
    @(posedge core_clk_i);
    s_axi_rready_i <= 1'b0;
  endtask
  always @(negedge core_clk_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i)
      check({s_axi_rresp_o, s_axi_rdata_o}, expq.pop_front());
    if (s_axi_bvalid_o && s_axi_bready_i)
      check({s_axi_bresp_o, 32'h0000_0000}, expq.pop_front());
  end
  task automatic src(input logic [4:0] v);
    @(posedge core_clk_i);
    rst_src_i <= v;
    @(posedge core_clk_i);
    rst_src_i <= '0;
  endtask
  task automatic lp(input logic stop);
    @(posedge core_clk_i);
    stop_exec_i <= stop;
    wait_exec_i <= !stop;
    @(posedge core_clk_i);
    stop_exec_i <= 1'b0;
    wait_exec_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic await(input logic sel, input int lim, output int n);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (!(sel ? force_swi_o : stack_start_o) && n < lim);
    check(34'(n < lim), 34'h1);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    int pos[5];
    logic [33:0] all;
    int n;
    pos = '{ELC_RC_LVI_BIT, ELC_RC_ILLAD_BIT, ELC_RC_ILLOP_BIT,
      ELC_RC_WDOG_BIT, ELC_RC_PIN_BIT};
    all = '0;
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(ELC_IDX_RST_CAUSE, 34'h1 << ELC_RC_POR_BIT);
    rd(ELC_IDX_RST_CAUSE, '0);
    rd(ELC_IDX_BRK_FCLR, '0);
    rd(ELC_IDX_BRK_EXIT, '0);
    wr(ELC_IDX_BRK_FCLR, 8'hff, ELC_RESP_OKAY);
    rd(ELC_IDX_BRK_FCLR, 34'h1 << ELC_BFC_ENABLE_BIT);
    rd(16'hfe02, {ELC_RESP_DECERR, 32'h0000_0000});
    wr(16'hfe02, 8'hff, ELC_RESP_DECERR);
    for (int i = 0; i < 5; i++) begin
      all = all | (34'h1 << pos[i]);
      src(5'(1 << i));
      rd(ELC_IDX_RST_CAUSE, 34'h1 << pos[i]);
    end
    src(5'h1f);
    rd(ELC_IDX_RST_CAUSE, all);
    lp(1'b0);
    check(34'(clk_en_o), 34'h7);
    check(34'({wdog_enable_o, wdog_run_o}), 34'h3);
    repeat (seed[2:0]) @(posedge core_clk_i);
    irq_req_i <= 1'b1;
    await(1'b0, 5, n);
    irq_req_i <= 1'b0;
    watchdog_disable_i <= 1'b1;
    lp(1'b0);
    check(34'({wdog_enable_o, wdog_run_o}), 34'h0);
    src(5'h01);
    @(negedge core_clk_i);
    check(34'(clk_en_o), 34'hf);
    rd(ELC_IDX_RST_CAUSE, 34'h1 << ELC_RC_LVI_BIT);
    short_stop_recovery_i <= 1'b1;
    lp(1'b1);
    check(34'(clk_en_o), 34'h0);
    brk_go <= 1'b1;
    @(posedge core_clk_i);
    brk_go <= 1'b0;
    await(1'b1, 300, n);
    check(34'(n >= DIV * 32 && n <= DIV * 32 + 8), 34'h1);
    @(negedge core_clk_i);
    check(34'({break_mode_o, flag_clear_allow_o}), 34'h3);
    rd(ELC_IDX_BRK_EXIT, 34'h1 << ELC_BRK_EXIT_BIT);
    wr(ELC_IDX_BRK_FCLR, 8'h00, ELC_RESP_OKAY);
    @(negedge core_clk_i);
    check(34'({break_mode_o, flag_clear_allow_o}), 34'h2);
    wr(ELC_IDX_BRK_EXIT, 8'h00, ELC_RESP_OKAY);
    rd(ELC_IDX_BRK_EXIT, '0);
    brk_end <= 1'b1;
    @(posedge core_clk_i);
    brk_end <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check(34'({break_mode_o, flag_clear_allow_o}), 34'h1);
    short_stop_recovery_i <= 1'b0;
    lp(1'b1);
    irq_req_i <= 1'b1;
    await(1'b0, 9000, n);
    irq_req_i <= 1'b0;
    check(34'(n >= DIV * 4096 && n <= DIV * 4096 + 8), 34'h1);
    conclude();
  end
  // Past the longest recovery
  initial begin
    #400_000;
    fail_count++;
    conclude();
  end
endmodule
bind exception_lowpower_control elc_monitor mon (
  .core_clk_i, .rst_b_i, .ce_i, .rst_src_i, .sys_reset_o, .stop_exec_i,
  .wait_exec_i, .irq_req_i, .clr_imask_o, .stack_start_o, .force_swi_o,
  .break_req_i, .break_mode_o, .flag_clear_allow_o, .watchdog_disable_i,
  .short_stop_recovery_i, .wdog_enable_o, .wdog_run_o,
  .crystal_clock_tick_i, .clk_en_o);
